// ---- rtl/bdsc_ctrl.sv ----
// Background debug status/control register, mode tracking and breakpoint request logic
//
// Notes on behaviour
// - Eight-bit status and control byte held here
// - One sixteen-bit breakpoint address, compared to bus
// - Registers reached only by serial debug commands
// - Permit bit write ignored while background active
// - Active, wait/stop, failure bits are read-only
// - Clock select writable at any time outside wait/stop
// - Permit gates entry; reset or a control write clears it
// - Active status one while awaiting serial commands
// - Breakpoint disabled ignores select and address
// - Force match enters background at instruction boundary
// - Tag match enters background only when executed
// - Clock select resets to alternate source
// - Wait/stop status shows low-power or forced exit
// - In wait/stop only background and status read commands complete
// - Background command pulls processor out of wait/stop
// - Failure bit set when access meets wait/stop
// - Data valid failure bit unused, reads zero
// - Breakpoint register via dedicated read/write commands
// - Breakpoint without permit raises software interrupt
`timescale 1ns/100ps
`include "bdsc_cfg.svh"

module bdsc_ctrl (
    input  wire logic                      clock,
    input  wire logic                      resetn,
    // Serial command port, one command per strobe
    input  wire logic                      cmd_valid,
    input  wire logic [2:0]                cmd_code,
    input  wire logic [`BDSC_BKPT_W-1:0]   cmd_wdata,
    output logic                           rsp_valid_r,
    output logic                           rsp_refused_r,
    output logic      [`BDSC_BKPT_W-1:0]   rsp_rdata_r,
    // Processor side
    input  wire logic [`BDSC_BKPT_W-1:0]   cpu_addr,
    input  wire logic                      cpu_addr_valid,
    input  wire logic                      cpu_opcode_fetch,
    input  wire logic                      cpu_instr_boundary,
    input  wire logic                      cpu_tag_exec,
    input  wire logic                      cpu_wait_stop,
    input  wire logic                      cpu_mem_fail_ws,
    output logic                           bdm_active_r,
    output logic                           tag_mark_r,
    output logic                           swi_req_r,
    output logic                           wake_req_r,
    output logic                           comm_clock_select_r
);

    // Control bits and status flops
    logic                      background_permit_r;
    logic                      breakpoint_enable_r;
    logic                      force_tag_select_r;
    logic                      wait_stop_status_r;
    logic                      wait_stop_failure_r;
    logic                      ws_forced_r;
    logic                      force_pend_r;
    bdsc_pkg::bdsc_state_t     state_r;
    bdsc_pkg::bdsc_state_t     state_nxt;

    // Breakpoint comparator results
    logic [`BDSC_BKPT_W-1:0]   match_addr;
    logic                      bkpt_hit;

    // Command decode
    wire logic                 in_active;
    wire logic                 in_waitstop;
    wire logic                 cmd_is_rd_status;
    wire logic                 cmd_is_wr_ctrl;
    wire logic                 cmd_is_rd_bkpt;
    wire logic                 cmd_is_wr_bkpt;
    wire logic                 cmd_is_bgnd;
    wire logic                 cmd_is_go;
    wire logic                 cmd_is_mem;
    wire logic                 cmd_refused;
    wire logic                 cmd_accepted;
    wire logic                 wr_ctrl_go;
    wire logic                 wr_bkpt_go;
    wire logic                 bgnd_go;
    wire logic                 go_go;
    wire logic                 force_hit;
    wire logic                 tag_hit;
    wire logic                 force_fire;
    wire logic                 break_req;
    wire logic                 break_enter;
    wire logic                 break_swi;
    wire logic                 wsf_set;
    wire logic                 wsf_clr;
    wire logic                 ws_exit;
    wire logic [`BDSC_CTL_W-1:0] status_byte;
    wire logic [`BDSC_BKPT_W-1:0] rsp_data_nxt;

    assign in_active   = (state_r == bdsc_pkg::BDSC_ST_ACTIVE);
    assign in_waitstop = (state_r == bdsc_pkg::BDSC_ST_WAITSTOP);

    // Only the serial command port reaches the registers; no processor bus path exists
    assign cmd_is_rd_status = cmd_valid & (cmd_code == bdsc_pkg::BDSC_CMD_READ_STATUS);
    assign cmd_is_wr_ctrl   = cmd_valid & (cmd_code == bdsc_pkg::BDSC_CMD_WRITE_CONTROL);
    assign cmd_is_rd_bkpt   = cmd_valid & (cmd_code == bdsc_pkg::BDSC_CMD_BREAKPOINT_READ_COMMAND);
    assign cmd_is_wr_bkpt   = cmd_valid & (cmd_code == bdsc_pkg::BDSC_CMD_BREAKPOINT_WRITE_COMMAND);
    assign cmd_is_bgnd      = cmd_valid & (cmd_code == bdsc_pkg::BDSC_CMD_BACKGROUND);
    assign cmd_is_go        = cmd_valid & (cmd_code == bdsc_pkg::BDSC_CMD_GO);
    assign cmd_is_mem       = cmd_valid & (cmd_code == bdsc_pkg::BDSC_CMD_MEM_ACCESS);

    // In wait/stop only background and status reads complete; the rest are refused
    // Status stays readable so the host can see why it is being refused
    assign cmd_refused  = cmd_valid & in_waitstop & ~cmd_is_bgnd & ~cmd_is_rd_status;
    assign cmd_accepted = cmd_valid & ~cmd_refused;

    assign wr_ctrl_go = cmd_is_wr_ctrl & ~cmd_refused;
    assign wr_bkpt_go = cmd_is_wr_bkpt & ~cmd_refused;
    // Background needs the permit bit; without it the command is answered but has no effect
    assign bgnd_go    = cmd_is_bgnd & background_permit_r & ~in_active;
    assign go_go      = cmd_is_go & in_active;

    // Background taken while asleep wakes the processor and marks the status
    assign ws_exit    = bgnd_go & in_waitstop;

    // Breakpoint kinds; the comparator already folds in the enable bit
    assign force_hit = bkpt_hit & force_tag_select_r;
    assign tag_hit   = bkpt_hit & ~force_tag_select_r & cpu_opcode_fetch;

    // A pending force request fires at the next instruction boundary
    assign force_fire = force_pend_r & cpu_instr_boundary;
    // A tagged opcode only counts if the processor really executes it
    assign break_req  = (force_fire | cpu_tag_exec) & ~in_active;
    assign break_enter = break_req & background_permit_r;
    assign break_swi   = break_req & ~background_permit_r;

    // Failure flag: set wins over the clear given by a clean access in the same cycle
    assign wsf_set = cpu_mem_fail_ws;
    assign wsf_clr = cmd_is_mem & ~cmd_refused;

    // Read-back byte; data valid failure is tied to zero
    assign status_byte = {background_permit_r,
                          in_active,
                          breakpoint_enable_r,
                          force_tag_select_r,
                          comm_clock_select_r,
                          wait_stop_status_r,
                          wait_stop_failure_r,
                          `BDSC_DV_FAIL_VALUE};

    // Reply data: status in the low byte, breakpoint address as a whole word
    assign rsp_data_nxt = cmd_is_rd_status ? {8'h00, status_byte} :
                          cmd_is_rd_bkpt   ? match_addr :
                                             16'h0000;

    // Mode tracking: run, low-power and background active
    // Breaks are not taken in wait/stop: no instruction boundary arrives there
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bdsc_pkg::BDSC_ST_RUN: begin
                if (break_enter) begin
                    state_nxt = bdsc_pkg::BDSC_ST_ACTIVE;
                end else if (cmd_is_bgnd && background_permit_r) begin
                    state_nxt = bdsc_pkg::BDSC_ST_ACTIVE;
                end else if (cpu_wait_stop) begin
                    state_nxt = bdsc_pkg::BDSC_ST_WAITSTOP;
                end
            end
            bdsc_pkg::BDSC_ST_WAITSTOP: begin
                if (bgnd_go) begin
                    state_nxt = bdsc_pkg::BDSC_ST_ACTIVE;
                end else if (!cpu_wait_stop) begin
                    state_nxt = bdsc_pkg::BDSC_ST_RUN;
                end
            end
            bdsc_pkg::BDSC_ST_ACTIVE: begin
                if (go_go) begin
                    state_nxt = bdsc_pkg::BDSC_ST_RUN;
                end
            end
            default: begin
                state_nxt = bdsc_pkg::BDSC_ST_RUN;
            end
        endcase
    end

    // State register; active status output mirrors the active state
    // Taking the output from the next state keeps it in step with state_r
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r      <= bdsc_pkg::BDSC_ST_RUN;
            bdm_active_r <= 1'h0;
        end else begin
            state_r      <= state_nxt;
            bdm_active_r <= (state_nxt == bdsc_pkg::BDSC_ST_ACTIVE);
        end
    end

    // Permit bit: written only outside active mode, cleared by reset or a control write
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            background_permit_r <= `BDSC_RST_PERMIT;
        end else if (wr_ctrl_go && !in_active) begin
            background_permit_r <= cmd_wdata[`BDSC_BIT_PERMIT];
        end
    end

    // Breakpoint configuration and clock select bits; status bit positions in the write are dropped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            breakpoint_enable_r <= `BDSC_RST_BKPT_EN;
            force_tag_select_r  <= `BDSC_RST_FORCE_TAG;
            comm_clock_select_r <= `BDSC_RST_CLK_SEL;
        end else if (wr_ctrl_go) begin
            breakpoint_enable_r <= cmd_wdata[`BDSC_BIT_BKPT_EN];
            force_tag_select_r  <= cmd_wdata[`BDSC_BIT_FORCE_TAG];
            comm_clock_select_r <= cmd_wdata[`BDSC_BIT_CLK_SEL];
        end
    end

    // Wait/stop status: live low-power level, or held after a forced exit
    // The held part lasts for the whole background session, so the host can
    // tell later that the user program had been sleeping
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ws_forced_r        <= 1'h0;
            wait_stop_status_r <= 1'h0;
        end else begin
            if (ws_exit) begin
                ws_forced_r <= 1'h1;
            end else if (go_go) begin
                ws_forced_r <= 1'h0;
            end
            wait_stop_status_r <= cpu_wait_stop | (ws_forced_r & ~go_go)
                                  | ws_exit;
        end
    end

    // Failure flag: only hardware sets it; writes to the control byte never touch it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_stop_failure_r <= 1'h0;
        end else if (wsf_set) begin
            wait_stop_failure_r <= 1'h1;
        end else if (wsf_clr) begin
            wait_stop_failure_r <= 1'h0;
        end
    end

    // Force requests wait here until the current instruction completes
    // Disabling the breakpoint drops a pending force so a stale match never fires
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            force_pend_r <= 1'h0;
        end else if (force_hit && !in_active) begin
            force_pend_r <= 1'h1;
        end else if (force_fire || in_active || !breakpoint_enable_r) begin
            force_pend_r <= 1'h0;
        end
    end

    // Processor-facing pulses: tag mark, software interrupt, wake-up
    // Each pulse stands one cycle; the processor must take it on the next edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tag_mark_r <= 1'h0;
            swi_req_r  <= 1'h0;
            wake_req_r <= 1'h0;
        end else begin
            tag_mark_r <= tag_hit & ~in_active;
            swi_req_r  <= break_swi;
            wake_req_r <= ws_exit;
        end
    end

    // Command answers: one pulse per command, one cycle after the strobe
    // Refused and write commands answer zero, so old read data never leaks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rsp_valid_r   <= 1'h0;
            rsp_refused_r <= 1'h0;
            rsp_rdata_r   <= 16'h0000;
        end else begin
            rsp_valid_r   <= cmd_valid;
            rsp_refused_r <= cmd_refused;
            rsp_rdata_r   <= cmd_accepted ? rsp_data_nxt : 16'h0000;
        end
    end

    // Match address and comparator; disabled breakpoint ignores the address
    // The comparator adds one cycle, so force and tag logic see a hit late
    bdsc_bkpt_match u_bkpt (
        .clock          (clock),
        .resetn         (resetn),
        .wr_en          (wr_bkpt_go),
        .wr_addr        (cmd_wdata),
        .cmp_en         (breakpoint_enable_r),
        .cpu_addr       (cpu_addr),
        .cpu_addr_valid (cpu_addr_valid),
        .match_addr_r   (match_addr),
        .hit_r          (bkpt_hit)
    );

endmodule : bdsc_ctrl

// ---- rtl/bdsc_cfg.svh ----
// Bit positions, reset values and widths of the background debug status/control block
`ifndef BDSC_CFG_SVH
`define BDSC_CFG_SVH

// Status/control byte layout
`define BDSC_CTL_W            8
`define BDSC_BIT_PERMIT       7
`define BDSC_BIT_ACTIVE       6
`define BDSC_BIT_BKPT_EN      5
`define BDSC_BIT_FORCE_TAG    4
`define BDSC_BIT_CLK_SEL      3
`define BDSC_BIT_WAIT_STOP    2
`define BDSC_BIT_WS_FAIL      1
`define BDSC_BIT_DV_FAIL      0

// Breakpoint match register width
`define BDSC_BKPT_W           16

// Reset values of writable control bits and the breakpoint match address
`define BDSC_RST_PERMIT       1'h0
`define BDSC_RST_BKPT_EN      1'h0
`define BDSC_RST_FORCE_TAG    1'h0
`define BDSC_RST_CLK_SEL      1'h0
`define BDSC_RST_BKPT_ADDR    16'h0000

// Data valid failure is tied off: no slow memory behind this controller
`define BDSC_DV_FAIL_VALUE    1'h0

`endif

// ---- rtl/bdsc_pkg.sv ----
// Types shared by the background debug status/control block
package bdsc_pkg;

    // Serial debug commands decoded by the link logic upstream
    typedef enum logic [2:0] {
        BDSC_CMD_READ_STATUS   = 3'h0,
        BDSC_CMD_WRITE_CONTROL = 3'h1,
        BDSC_CMD_BREAKPOINT_READ_COMMAND     = 3'h2,
        BDSC_CMD_BREAKPOINT_WRITE_COMMAND    = 3'h3,
        BDSC_CMD_BACKGROUND    = 3'h4,
        BDSC_CMD_GO            = 3'h5,
        BDSC_CMD_MEM_ACCESS    = 3'h6
    } bdsc_cmd_t;

    // Processor mode as seen by the debug controller
    typedef enum logic [2:0] {
        BDSC_ST_RUN       = 3'b001,
        BDSC_ST_WAITSTOP  = 3'b010,
        BDSC_ST_ACTIVE    = 3'b100
    } bdsc_state_t;

endpackage : bdsc_pkg

// ---- rtl/bdsc_bkpt_match.sv ----
// Breakpoint match address holder and address comparator
`timescale 1ns/100ps
`include "bdsc_cfg.svh"

module bdsc_bkpt_match (
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire logic                      wr_en,
    input  wire logic [`BDSC_BKPT_W-1:0]   wr_addr,
    input  wire logic                      cmp_en,
    input  wire logic [`BDSC_BKPT_W-1:0]   cpu_addr,
    input  wire logic                      cpu_addr_valid,
    output logic      [`BDSC_BKPT_W-1:0]   match_addr_r,
    output logic                           hit_r
);

    logic hit_nxt;

    // Compare only when enabled; a disabled breakpoint never reports a hit
    assign hit_nxt = cmp_en & cpu_addr_valid & (cpu_addr == match_addr_r);

    // Match register is written only by the breakpoint write command
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            match_addr_r <= `BDSC_RST_BKPT_ADDR;
            hit_r        <= 1'h0;
        end else begin
            if (wr_en) begin
                match_addr_r <= wr_addr;
            end
            hit_r <= hit_nxt;
        end
    end

endmodule : bdsc_bkpt_match

// ---- bench/bdsc_ctrl_properties.sv ----
// Port-level assertions for the debug status/control block
`timescale 1ns/100ps
`include "bdsc_cfg.svh"

module bdsc_ctrl_properties (
    input wire logic                    clock,
    input wire logic                    resetn,
    input wire logic                    cmd_valid,
    input wire logic [2:0]              cmd_code,
    input wire logic                    rsp_valid_r,
    input wire logic [`BDSC_BKPT_W-1:0] rsp_rdata_r,
    input wire logic                    cpu_addr_valid,
    input wire logic                    cpu_opcode_fetch,
    input wire logic                    cpu_instr_boundary,
    input wire logic                    cpu_tag_exec,
    input wire logic                    bdm_active_r,
    input wire logic                    tag_mark_r,
    input wire logic                    swi_req_r,
    input wire logic                    wake_req_r,
    input wire logic                    comm_clock_select_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // Status read taken on the previous edge; registered so the properties stay short
    logic rd_st_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            rd_st_r <= 1'b0;
        else
            rd_st_r <= cmd_valid && cmd_code == bdsc_pkg::BDSC_CMD_READ_STATUS;
    end

    a_cmd_answered: assert property (cmd_valid |=> rsp_valid_r)
        else $error("command not answered next cycle");
    a_status_fixed_bits: assert property (rd_st_r |-> rsp_rdata_r[15:8] == 8'h00 && !rsp_rdata_r[0])
        else $error("status upper byte or data valid bit not zero");
    a_status_active_bit: assert property (rd_st_r && $stable(bdm_active_r) |-> rsp_rdata_r[6] == bdm_active_r)
        else $error("status active bit disagrees with active output");
    a_status_clock_bit: assert property (rd_st_r && $stable(comm_clock_select_r)
        |-> rsp_rdata_r[3] == comm_clock_select_r)
        else $error("status clock bit disagrees with clock select output");
    a_tag_after_fetch: assert property (tag_mark_r |-> $past(cpu_opcode_fetch) && $past(cpu_addr_valid, 2))
        else $error("tag without matching address and fetch");
    a_swi_not_active: assert property (swi_req_r |-> !bdm_active_r)
        else $error("software interrupt while background active");
    a_wake_enters_bg: assert property (wake_req_r |-> bdm_active_r && $past(cmd_valid)
        && $past(cmd_code) == bdsc_pkg::BDSC_CMD_BACKGROUND)
        else $error("wake without background command");
    a_leave_by_go: assert property ($fell(bdm_active_r) |-> $past(cmd_valid)
        && $past(cmd_code) == bdsc_pkg::BDSC_CMD_GO)
        else $error("background left without go command");
    a_enter_has_cause: assert property ($rose(bdm_active_r) |-> ($past(cmd_valid)
        && $past(cmd_code) == bdsc_pkg::BDSC_CMD_BACKGROUND) || $past(cpu_instr_boundary)
        || $past(cpu_instr_boundary, 2) || $past(cpu_tag_exec) || $past(cpu_tag_exec, 2))
        else $error("background entered without cause");
endmodule : bdsc_ctrl_properties

bind bdsc_ctrl bdsc_ctrl_properties u_props (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .rsp_valid_r(rsp_valid_r), .rsp_rdata_r(rsp_rdata_r), .cpu_addr_valid(cpu_addr_valid),
    .cpu_opcode_fetch(cpu_opcode_fetch), .cpu_instr_boundary(cpu_instr_boundary), .cpu_tag_exec(cpu_tag_exec),
    .bdm_active_r(bdm_active_r), .tag_mark_r(tag_mark_r), .swi_req_r(swi_req_r), .wake_req_r(wake_req_r),
    .comm_clock_select_r(comm_clock_select_r));

// ---- bench/bdsc_host_model.sv ----
// Debug host model issuing serial commands toward the controller
`timescale 1ns/100ps

module bdsc_host_model (
    input  wire logic        clock,
    output logic             cmd_valid,
    output logic [2:0]       cmd_code,
    output logic [15:0]      cmd_wdata
);
    // Idle command port at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 3'h0;
        cmd_wdata = 16'h0000;
    end

    // One strobe per command; released data is inverted so a stale value never passes
    task automatic send(input logic [2:0] code, input logic [15:0] wdata);
        @(negedge clock);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_wdata <= wdata;
        @(negedge clock);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~wdata;
    endtask : send
endmodule : bdsc_host_model

// ---- bench/bdsc_ctrl_bench.sv ----
// Self-checking bench for the debug status/control block
`timescale 1ns/100ps

module bdsc_ctrl_bench;
    localparam bdsc_pkg::bdsc_cmd_t RS = bdsc_pkg::BDSC_CMD_READ_STATUS, WC = bdsc_pkg::BDSC_CMD_WRITE_CONTROL,
        RB = bdsc_pkg::BDSC_CMD_BREAKPOINT_READ_COMMAND, WB = bdsc_pkg::BDSC_CMD_BREAKPOINT_WRITE_COMMAND, BG = bdsc_pkg::BDSC_CMD_BACKGROUND,
        GO = bdsc_pkg::BDSC_CMD_GO, MA = bdsc_pkg::BDSC_CMD_MEM_ACCESS;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        cmd_valid, rsp_valid_r, rsp_refused_r, bdm_active_r, tag_mark_r, swi_req_r, wake_req_r;
    logic        comm_clock_select_r;
    logic [2:0]  cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata_r, bk;
    logic [15:0] cpu_addr = 16'h0000;
    logic        cpu_addr_valid = 1'b0, cpu_opcode_fetch = 1'b0, cpu_instr_boundary = 1'b0;
    logic        cpu_tag_exec = 1'b0, cpu_wait_stop = 1'b0, cpu_mem_fail_ws = 1'b0;
    logic [16:0] exp_q[$];
    int          n_mismatch = 0, compares = 0, swi_seen = 0, wake_seen = 0;

    always #5 clock = ~clock;

    bdsc_host_model u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    bdsc_ctrl u_dut (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r), .rsp_refused_r(rsp_refused_r), .rsp_rdata_r(rsp_rdata_r),
        .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid), .cpu_opcode_fetch(cpu_opcode_fetch),
        .cpu_instr_boundary(cpu_instr_boundary), .cpu_tag_exec(cpu_tag_exec), .cpu_wait_stop(cpu_wait_stop),
        .cpu_mem_fail_ws(cpu_mem_fail_ws), .bdm_active_r(bdm_active_r), .tag_mark_r(tag_mark_r),
        .swi_req_r(swi_req_r), .wake_req_r(wake_req_r), .comm_clock_select_r(comm_clock_select_r));

    task automatic wrap_up;
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Note the expected answer first, then let the host send the command
    task automatic cmd(input logic [2:0] code, input logic [15:0] wdata, input logic [16:0] exp);
        exp_q.push_back(exp);
        u_host.send(code, wdata);
    endtask : cmd

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick

    // Address cycle on the match value, then optional opcode fetch in the next cycle
    task automatic hit(input logic fetch);
        cpu_addr = bk;
        cpu_addr_valid = 1'b1;
        tick(1);
        cpu_addr = ~bk;
        cpu_addr_valid = 1'b0;
        cpu_opcode_fetch = fetch;
        tick(1);
        cpu_opcode_fetch = 1'b0;
    endtask : hit

    task automatic boundary;
        cpu_instr_boundary = 1'b1;
        tick(1);
        cpu_instr_boundary = 1'b0;
        tick(1);
    endtask : boundary

    // Response watcher: each answer against the oldest note; interrupt and wake pulses tallied
    always @(negedge clock) begin
        if (rsp_valid_r === 1'b1)
            chk({rsp_refused_r, rsp_rdata_r}, exp_q.pop_front());
        if (swi_req_r === 1'b1)
            swi_seen++;
        if (wake_req_r === 1'b1)
            wake_seen++;
    end

    // Watchdog well beyond the hundred or fewer cycles the sequence needs
    initial begin
        repeat (3000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end

    // Main sequence
    initial begin
        void'($urandom(34525));
        bk = 16'($urandom());
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        cmd(RS, 16'h0000, 17'h0_0000);
        chk({16'h0000, comm_clock_select_r}, 17'h0_0000);
        cmd(WC, 16'h00FF, 17'h0_0000);
        cmd(RS, 16'h0000, 17'h0_00B8);
        chk({16'h0000, comm_clock_select_r}, 17'h0_0001);
        cmd(WB, bk, 17'h0_0000);
        cmd(RB, 16'h0000, {1'b0, bk});
        hit(1'b0);
        boundary();
        chk({16'h0000, bdm_active_r}, 17'h0_0001);
        cmd(RS, 16'h0000, 17'h0_00F8);
        cmd(WC, 16'h0020, 17'h0_0000);
        cmd(RS, 16'h0000, 17'h0_00E0);
        cmd(GO, 16'h0000, 17'h0_0000);
        cmd(RS, 16'h0000, 17'h0_00A0);
        hit(1'b1);
        chk({16'h0000, tag_mark_r}, 17'h0_0001);
        cpu_tag_exec = 1'b1;
        tick(1);
        cpu_tag_exec = 1'b0;
        tick(1);
        chk({16'h0000, bdm_active_r}, 17'h0_0001);
        cmd(GO, 16'h0000, 17'h0_0000);
        // Tag select with the breakpoint off must not mark, then force select must not break
        cmd(WC, 16'h0080, 17'h0_0000);
        hit(1'b1);
        chk({16'h0000, tag_mark_r}, 17'h0_0000);
        cmd(WC, 16'h0090, 17'h0_0000);
        hit(1'b0);
        boundary();
        chk({16'h0000, bdm_active_r}, 17'h0_0000);
        cmd(WC, 16'h0030, 17'h0_0000);
        hit(1'b0);
        boundary();
        chk({16'h0000, bdm_active_r}, 17'h0_0000);
        chk(17'(swi_seen), 17'h0_0001);
        cmd(BG, 16'h0000, 17'h0_0000);
        chk({16'h0000, bdm_active_r}, 17'h0_0000);
        cmd(WC, 16'h0080, 17'h0_0000);
        cpu_wait_stop = 1'b1;
        cmd(RS, 16'h0000, 17'h0_0084);
        cmd(WB, bk, 17'h1_0000);
        cpu_mem_fail_ws = 1'b1;
        tick(1);
        cpu_mem_fail_ws = 1'b0;
        cmd(RS, 16'h0000, 17'h0_0086);
        cmd(BG, 16'h0000, 17'h0_0000);
        chk({16'h0000, bdm_active_r}, 17'h0_0001);
        // Let the watcher tally the wake pulse before its count is read
        tick(1);
        chk(17'(wake_seen), 17'h0_0001);
        cpu_wait_stop = 1'b0;
        cmd(RS, 16'h0000, 17'h0_00C6);
        cmd(MA, 16'h0000, 17'h0_0000);
        cmd(RS, 16'h0000, 17'h0_00C4);
        cmd(GO, 16'h0000, 17'h0_0000);
        cmd(RS, 16'h0000, 17'h0_0080);
        // Give the watcher the last answer before reset wipes it
        tick(1);
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        cmd(RS, 16'h0000, 17'h0_0000);
        tick(2);
        // Every noted command must have been answered
        chk(17'(exp_q.size()), 17'h0_0000);
        wrap_up();
    end
endmodule : bdsc_ctrl_bench
